// ==== rtl/mix_pkg.sv ====
// ***********************************************************
// widths, constants and shared arithmetic
// ***********************************************************
package mix_pkg;
  // datapath widths
  localparam int SW = 16;
  localparam int GW = 11;
  localparam int KW = 12;
  localparam int OW = 13;
  localparam int TW = 8;
  // binary point positions of the multiplier coefficients
  localparam int ROT_FRAC = 15;
  localparam int GAIN_FRAC = 10;
  localparam int SKEW_FRAC = 12;
  // eighth-rate trig terms, one and sqrt(1/2) in q15
  localparam logic [15:0] TRIG_ONE = 16'h7FFF;
  localparam logic [15:0] TRIG_HALF = 16'h5A82;
  // saturation limits of a sample
  localparam logic [15:0] SMAX = 16'h7FFF;
  localparam logic [15:0] SMIN = 16'h8000;
  localparam logic signed [33:0] LIM_HI = 34'sh000007FFF;
  localparam logic signed [33:0] LIM_LO = 34'sh3FFFF8000;
  // mix select bit positions
  localparam int CM_EIGHTH = 3;
  localparam int CM_PLUS4 = 2;
  localparam int CM_HALF = 1;
  localparam int CM_MINUS4 = 0;
  // supported mix select codes
  localparam logic [3:0] CM_NONE = 4'h0;
  localparam logic [3:0] CM_M4 = 4'h1;
  localparam logic [3:0] CM_H2 = 4'h2;
  localparam logic [3:0] CM_P4 = 4'h4;
  localparam logic [3:0] CM_P8 = 4'h8;
  localparam logic [3:0] CM_M38 = 4'hA;
  localparam logic [3:0] CM_P38 = 4'hC;
  localparam logic [3:0] CM_M8 = 4'hE;
  // register word indices (byte address = 4 x index)
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_STAT = 6'h01;
  localparam logic [5:0] IDX_GAIN = 6'h04;
  localparam logic [5:0] IDX_SKEW = 6'h08;
  localparam logic [5:0] IDX_DC = 6'h0C;
  localparam logic [5:0] IDX_TRIM = 6'h10;
  // control word field: multiplier unscaled option
  localparam int CTRL_UNSCALED = 4;
  // reset values, and the position that follows a sync sample
  localparam logic [10:0] GAIN_RST = 11'h400;
  localparam logic [3:0] CMIX_RST = 4'h0;
  localparam logic [2:0] POS_ONE = 3'h1;

  // clamp a wide signed value to one sample
  function automatic logic [15:0] sat16(input logic signed [33:0] v);
    if (v > LIM_HI) begin
      return SMAX;
    end else if (v < LIM_LO) begin
      return SMIN;
    end
    return v[15:0];
  endfunction
endpackage

// ==== rtl/dc_shift_stage.sv ====
`timescale 1ns/100ps
// ***********************************************************
// per-channel offset add and timing trim output
// ***********************************************************
module dc_shift_stage (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // corrected sample in
  input wire logic in_valid,
  input wire logic [15:0] din,
  // channel settings
  input wire logic [12:0] dc_shift,
  input wire logic [7:0] timing_trim,
  // converter core side
  output logic out_valid,
  output logic [15:0] dout,
  output logic [7:0] trim_out
);
  // all state of the stage
  typedef struct packed {
    logic v;
    logic [15:0] d;
    logic [7:0] t;
  } stage_t;

  stage_t st_r;
  stage_t st_nxt;
  logic signed [33:0] sum; // offset plus sample, never wraps

  // ***********************************************************
  // offset add
  // ***********************************************************
  // lsb-aligned add, clamped at the sample limits
  always_comb begin
    st_nxt = st_r;
    sum = 34'($signed(din)) + 34'($signed(dc_shift));
    st_nxt.v = in_valid;
    st_nxt.t = timing_trim;
    if (in_valid) begin
      st_nxt.d = mix_pkg::sat16(sum);
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign out_valid = st_r.v;
  assign dout = st_r.d;
  assign trim_out = st_r.t;

  // non-negative offset never lowers a non-negative sample
  property p_no_wrap;
    @(posedge clock) disable iff (rst)
    (in_valid && !din[15] && !dc_shift[12])
      |=> ($signed(dout) >= $signed($past(din)));
  endproperty
  a_no_wrap: assert property (p_no_wrap)
    else $error("offset add wrapped");

  // in-range sums come out exact
  property p_exact_add;
    @(posedge clock) disable iff (rst)
    (in_valid && sum <= mix_pkg::LIM_HI && sum >= mix_pkg::LIM_LO)
      |=> (dout == $past(sum[15:0]));
  endproperty
  a_exact_add: assert property (p_exact_add)
    else $error("offset add not exact");
endmodule

// ==== rtl/coarse_mixer_qmc_datapath.sv ====
`timescale 1ns/100ps
module coarse_mixer_qmc_datapath (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // avalon-mm register slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // complex samples from interpolation
  input wire logic in_valid,
  input wire logic in_sync,
  input wire logic [15:0] ab_i,
  input wire logic [15:0] ab_q,
  input wire logic [15:0] cd_i,
  input wire logic [15:0] cd_q,
  // converter cores
  output logic out_valid,
  output logic [15:0] ch1_data,
  output logic [15:0] ch2_data,
  output logic [15:0] ch3_data,
  output logic [15:0] ch4_data,
  output logic [7:0] ch1_trim,
  output logic [7:0] ch2_trim,
  output logic [7:0] ch3_trim,
  output logic [7:0] ch4_trim
);
  // ***********************************************************
  // state
  // ***********************************************************
  // channel index: 0 ab i, 1 ab q, 2 cd i, 3 cd q
  typedef struct packed {
    logic busy_n;              // waitrequest flop
    logic [31:0] rdata;        // read answer
    logic [3:0] cmix;          // coarse mix select
    logic unscaled;            // multiplier unscaled option
    logic [3:0][10:0] gain;    // per-channel gain
    logic [1:0][11:0] skew;    // per-pair skew term
    logic [3:0][12:0] dc;      // per-channel offset
    logic [3:0][7:0] trim;     // per-channel timing trim
    logic [2:0] pos;           // sample position, low bits mod 4
    logic v1;                  // after eighth-rate multiply
    logic [1:0] p1;
    logic [3:0][15:0] s1;
    logic v2;                  // after swap mixers
    logic [3:0][15:0] s2;
    logic v3;                  // after gain and skew
    logic [3:0][15:0] s3;
  } state_t;

  localparam state_t ST_RST = '{
    busy_n: 1'b1,
    cmix: mix_pkg::CMIX_RST,
    gain: {4{mix_pkg::GAIN_RST}},
    default: '0
  };

  state_t st_r;
  state_t st_nxt;
  logic [5:0] idx;          // word index of the bus address
  logic [31:0] rd;          // current value of addressed register
  logic [31:0] wr;          // byte-merged write value
  logic [2:0] use_pos;      // position given to this sample
  logic [15:0] ci;          // eighth-rate cosine
  logic [15:0] sn;          // eighth-rate sine
  logic [1:0] quad;         // quarter turns for the swap mixers
  logic [3:0][15:0] din;    // input samples as an array
  logic [3:0] o_v;          // stage valid per channel
  logic [3:0][15:0] o_d;    // stage data per channel
  logic [3:0][7:0] o_t;     // stage trim per channel

  // ***********************************************************
  // helpers
  // ***********************************************************
  // a*x +/- b*y rescaled from q15, halved unless unscaled
  function automatic logic [15:0] mac2(input logic [15:0] a,
      input logic [15:0] x, input logic [15:0] b,
      input logic [15:0] y, input logic sub, input logic unsc);
    logic signed [33:0] acc;
    acc = 34'($signed(a) * $signed(x));
    if (sub) begin
      acc = acc - 34'($signed(b) * $signed(y));
    end else begin
      acc = acc + 34'($signed(b) * $signed(y));
    end
    if (unsc) begin
      acc = acc >>> mix_pkg::ROT_FRAC;
    end else begin
      acc = acc >>> (mix_pkg::ROT_FRAC + 1);
    end
    return mix_pkg::sat16(acc);
  endfunction

  // negation that clamps the most negative sample
  function automatic logic [15:0] neg(input logic [15:0] x);
    return mix_pkg::sat16(-34'($signed(x)));
  endfunction

  // sample times a signed coefficient, scaled down by sh
  function automatic logic signed [33:0] scale(input logic [15:0] x,
      input logic [12:0] k, input int sh);
    return 34'($signed(x) * $signed(k)) >>> sh;
  endfunction

  // rotation by quarter turns: {i, q}
  function automatic logic [31:0] rot(input logic [15:0] i,
      input logic [15:0] q, input logic [1:0] r);
    case (r)
      2'h0: return {i, q};
      2'h1: return {neg(q), i};
      2'h2: return {neg(i), neg(q)};
      default: return {q, neg(i)};
    endcase
  endfunction

  // eighth-rate cosine and sine for position k: {cos, sin}
  function automatic logic [31:0] trig(input logic [2:0] k);
    case (k)
      3'h0: return {mix_pkg::TRIG_ONE, 16'h0000};
      3'h1: return {mix_pkg::TRIG_HALF, mix_pkg::TRIG_HALF};
      3'h2: return {16'h0000, mix_pkg::TRIG_ONE};
      3'h3: return {neg(mix_pkg::TRIG_HALF), mix_pkg::TRIG_HALF};
      3'h4: return {neg(mix_pkg::TRIG_ONE), 16'h0000};
      3'h5: return {neg(mix_pkg::TRIG_HALF), neg(mix_pkg::TRIG_HALF)};
      3'h6: return {16'h0000, neg(mix_pkg::TRIG_ONE)};
      default: return {mix_pkg::TRIG_HALF, neg(mix_pkg::TRIG_HALF)};
    endcase
  endfunction

  // supported select codes
  function automatic logic code_ok(input logic [3:0] c);
    return c inside {mix_pkg::CM_NONE, mix_pkg::CM_M4, mix_pkg::CM_H2,
      mix_pkg::CM_P4, mix_pkg::CM_P8, mix_pkg::CM_M38, mix_pkg::CM_P38,
      mix_pkg::CM_M8};
  endfunction

  // byte-lane merge of a write into the old word
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        m[8*b +: 8] = d[8*b +: 8];
      end
    end
    return m;
  endfunction

  assign din = {cd_q, cd_i, ab_q, ab_i};
  assign idx = address[7:2];

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb begin
    st_nxt = st_r;
    // register read mux, unmapped words read zero
    rd = 32'h0000_0000;
    if (idx == mix_pkg::IDX_CTRL) begin
      rd = {27'h0, st_r.unscaled, st_r.cmix};
    end else if (idx == mix_pkg::IDX_STAT) begin
      rd = {28'h0, !code_ok(st_r.cmix), st_r.pos};
    end else if (idx[5:2] == mix_pkg::IDX_GAIN[5:2]) begin
      rd = {21'h0, st_r.gain[idx[1:0]]};
    end else if (idx[5:1] == mix_pkg::IDX_SKEW[5:1]) begin
      rd = {20'h0, st_r.skew[idx[0]]};
    end else if (idx[5:2] == mix_pkg::IDX_DC[5:2]) begin
      rd = {19'h0, st_r.dc[idx[1:0]]};
    end else if (idx[5:2] == mix_pkg::IDX_TRIM[5:2]) begin
      rd = {24'h0, st_r.trim[idx[1:0]]};
    end
    wr = merge(rd, writedata, byteenable);

    // bus: first cycle latches the answer, second completes it
    if ((read || write) && st_r.busy_n) begin
      st_nxt.busy_n = 1'b0;
      st_nxt.rdata = read ? rd : 32'h0000_0000;
    end else if (!st_r.busy_n) begin
      st_nxt.busy_n = 1'b1;
      if (write) begin
        if (idx == mix_pkg::IDX_CTRL) begin
          st_nxt.cmix = wr[3:0];
          st_nxt.unscaled = wr[mix_pkg::CTRL_UNSCALED];
        end else if (idx[5:2] == mix_pkg::IDX_GAIN[5:2]) begin
          st_nxt.gain[idx[1:0]] = wr[10:0];
        end else if (idx[5:1] == mix_pkg::IDX_SKEW[5:1]) begin
          st_nxt.skew[idx[0]] = wr[11:0];
        end else if (idx[5:2] == mix_pkg::IDX_DC[5:2]) begin
          st_nxt.dc[idx[1:0]] = wr[12:0];
        end else if (idx[5:2] == mix_pkg::IDX_TRIM[5:2]) begin
          st_nxt.trim[idx[1:0]] = wr[7:0];
        end
      end
    end

    // position: sync restarts at the first sample of the cycle
    use_pos = in_sync ? 3'h0 : st_r.pos;
    if (in_valid) begin
      st_nxt.pos = 3'(use_pos + 3'h1);
    end

    // stage 1: eighth-rate rotation through the multiplier
    {ci, sn} = trig(use_pos);
    st_nxt.v1 = in_valid;
    if (in_valid) begin
      st_nxt.p1 = use_pos[1:0];
      st_nxt.s1 = din;
      if (st_r.cmix[mix_pkg::CM_EIGHTH]) begin
        for (int p = 0; p < 2; p++) begin
          st_nxt.s1[2*p] = mac2(din[2*p], ci, din[2*p+1], sn,
            1'b1, st_r.unscaled);
          st_nxt.s1[2*p+1] = mac2(din[2*p+1], ci, din[2*p], sn,
            1'b0, st_r.unscaled);
        end
      end
    end

    // stage 2: swap mixers as quarter turns, no multiplier
    quad = 2'(
      (st_r.cmix[mix_pkg::CM_PLUS4] ? st_r.p1 : 2'h0)
      + (st_r.cmix[mix_pkg::CM_HALF] ? {st_r.p1[0], 1'b0} : 2'h0)
      - (st_r.cmix[mix_pkg::CM_MINUS4] ? st_r.p1 : 2'h0));
    st_nxt.v2 = st_r.v1;
    if (st_r.v1) begin
      for (int p = 0; p < 2; p++) begin
        {st_nxt.s2[2*p], st_nxt.s2[2*p+1]} =
          rot(st_r.s1[2*p], st_r.s1[2*p+1], quad);
      end
    end

    // stage 3: gain on both paths, skew of Q summed into I
    st_nxt.v3 = st_r.v2;
    if (st_r.v2) begin
      for (int p = 0; p < 2; p++) begin
        st_nxt.s3[2*p] = mix_pkg::sat16(
          scale(st_r.s2[2*p], {2'b00, st_r.gain[2*p]},
            mix_pkg::GAIN_FRAC)
          + scale(st_r.s2[2*p+1], {st_r.skew[p][11], st_r.skew[p]},
            mix_pkg::SKEW_FRAC));
        st_nxt.s3[2*p+1] = mix_pkg::sat16(
          scale(st_r.s2[2*p+1], {2'b00, st_r.gain[2*p+1]},
            mix_pkg::GAIN_FRAC));
      end
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ***********************************************************
  // offset and trim per channel
  // ***********************************************************
  for (genvar c = 0; c < 4; c++) begin : g_ch
    dc_shift_stage u_stage (
      .clock(clock),
      .rst(rst),
      .in_valid(st_r.v3),
      .din(st_r.s3[c]),
      .dc_shift(st_r.dc[c]),
      .timing_trim(st_r.trim[c]),
      .out_valid(o_v[c]),
      .dout(o_d[c]),
      .trim_out(o_t[c])
    );
  end

  assign readdata = st_r.rdata;
  assign waitrequest = st_r.busy_n;
  assign out_valid = o_v[0];
  assign ch1_data = o_d[0];
  assign ch2_data = o_d[1];
  assign ch3_data = o_d[2];
  assign ch4_data = o_d[3];
  assign ch1_trim = o_t[0];
  assign ch2_trim = o_t[1];
  assign ch3_trim = o_t[2];
  assign ch4_trim = o_t[3];

  // ***********************************************************
  // checks
  // ***********************************************************
  property p_bypass;
    @(posedge clock) disable iff (rst)
    (in_valid && st_r.cmix == mix_pkg::CM_NONE)
      |-> ##2 (st_r.s2[0] == $past(ab_i, 2)
        && st_r.s2[3] == $past(cd_q, 2));
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass changed a sample");

  property p_half_rate;
    @(posedge clock) disable iff (rst)
    (in_valid && !in_sync && st_r.cmix == mix_pkg::CM_H2
      && st_r.pos[0] && ab_i != mix_pkg::SMIN)
      |-> ##2 (st_r.s2[0] == 16'(-$past(ab_i, 2)));
  endproperty
  a_half_rate: assert property (p_half_rate)
    else $error("fs/2 odd sample not negated");

  property p_plus_quarter;
    @(posedge clock) disable iff (rst)
    (in_valid && !in_sync && st_r.cmix == mix_pkg::CM_P4
      && st_r.pos[1:0] == 2'h1 && ab_q != mix_pkg::SMIN)
      |-> ##2 (st_r.s2[0] == 16'(-$past(ab_q, 2))
        && st_r.s2[1] == $past(ab_i, 2));
  endproperty
  a_plus_quarter: assert property (p_plus_quarter)
    else $error("+fs/4 second sample wrong");

  property p_minus_quarter;
    @(posedge clock) disable iff (rst)
    (in_valid && !in_sync && st_r.cmix == mix_pkg::CM_M4
      && st_r.pos[1:0] == 2'h1)
      |-> ##2 (st_r.s2[0] == $past(ab_q, 2));
  endproperty
  a_minus_quarter: assert property (p_minus_quarter)
    else $error("-fs/4 second sample wrong");

  property p_pos_step;
    @(posedge clock) disable iff (rst)
    (in_valid && !in_sync) |=> st_r.pos == 3'($past(st_r.pos) + 3'h1);
  endproperty
  a_pos_step: assert property (p_pos_step)
    else $error("position did not advance");

  property p_pos_sync;
    @(posedge clock) disable iff (rst)
    (in_valid && in_sync) |=> st_r.pos == mix_pkg::POS_ONE;
  endproperty
  a_pos_sync: assert property (p_pos_sync)
    else $error("sync did not restart position");

  property p_halved;
    @(posedge clock) disable iff (rst)
    (in_valid && st_r.cmix == mix_pkg::CM_P8
      && !st_r.unscaled && (in_sync || st_r.pos == 3'h0))
      |=> ($signed(st_r.s1[0]) <= ($signed($past(ab_i)) >>> 1)
        && $signed(st_r.s1[0]) >= ($signed($past(ab_i)) >>> 1) - 1);
  endproperty
  a_halved: assert property (p_halved)
    else $error("multiplier output not halved");

  property p_unit_gain;
    @(posedge clock) disable iff (rst)
    (st_r.v2 && st_r.gain[0] == mix_pkg::GAIN_RST && st_r.skew[0] == '0)
      |=> st_r.s3[0] == $past(st_r.s2[0]);
  endproperty
  a_unit_gain: assert property (p_unit_gain)
    else $error("unit gain altered the sample");
endmodule

// ==== verif/interp_source.sv ====
`timescale 1ns/100ps
// ***********************************************************
// upstream interpolation source model
// ***********************************************************
module interp_source (
  // clock
  input wire logic clock,
  // complex samples out
  output logic in_valid,
  output logic in_sync,
  output logic [15:0] ab_i,
  output logic [15:0] ab_q,
  output logic [15:0] cd_i,
  output logic [15:0] cd_q
);
  // quiet lines at time zero
  initial begin
    in_valid = 1'b0;
    in_sync = 1'b0;
    {ab_i, ab_q, cd_i, cd_q} = 64'h0;
  end

  // present one sample, held up to the taking edge
  task automatic send(input logic s, input logic [15:0] ai, aq, ci, cq);
    in_valid <= 1'b1;
    in_sync <= s;
    ab_i <= ai;
    ab_q <= aq;
    cd_i <= ci;
    cd_q <= cq;
    @(posedge clock);
  endtask

  // idle: no strobe, data lines flip so stale values never look valid
  task automatic idle(input int n);
    in_valid <= 1'b0;
    in_sync <= 1'b0;
    {ab_i, ab_q, cd_i, cd_q} <= ~{ab_i, ab_q, cd_i, cd_q};
    repeat (n) @(posedge clock);
  endtask
endmodule

// ==== verif/coarse_mixer_qmc_datapath_tb.sv ====
`timescale 1ns/100ps
// ***********************************************************
// self-checking bench for the mixer and correction datapath
// ***********************************************************
`define CHK(g, e, m) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("CHECK FAILED t=%0t %s", $time, m); \
  end \
end
module coarse_mixer_qmc_datapath_tb;
  logic clock, rst, read, write, waitrequest, in_valid, in_sync, out_valid;
  logic [7:0] address; // bus byte address
  logic [31:0] writedata, readdata, q;
  logic [3:0] byteenable;
  logic [15:0] ab_i, ab_q, cd_i, cd_q, ch1_data, ch2_data, ch3_data, ch4_data;
  logic [7:0] ch1_trim, ch2_trim, ch3_trim, ch4_trim;
  logic [63:0] outq[$]; // captured output samples
  logic [3:0] modes[4];
  logic [3:0] eights[4];
  logic [31:0] e, f;
  int fails, check_count;

  coarse_mixer_qmc_datapath DUT (.clock(clock), .rst(rst),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .in_valid(in_valid), .in_sync(in_sync),
    .ab_i(ab_i), .ab_q(ab_q), .cd_i(cd_i), .cd_q(cd_q),
    .out_valid(out_valid), .ch1_data(ch1_data), .ch2_data(ch2_data),
    .ch3_data(ch3_data), .ch4_data(ch4_data), .ch1_trim(ch1_trim),
    .ch2_trim(ch2_trim), .ch3_trim(ch3_trim), .ch4_trim(ch4_trim));

  interp_source src (.clock(clock), .in_valid(in_valid),
    .in_sync(in_sync), .ab_i(ab_i), .ab_q(ab_q), .cd_i(cd_i), .cd_q(cd_q));

  // clock generation, 4 ns period
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // capture every output sample
  always @(posedge clock) begin
    if (out_valid === 1'b1) begin
      outq.push_back({ch1_data, ch2_data, ch3_data, ch4_data});
    end
  end

  // avalon cycle: hold until waitrequest low, take data at that edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    r = readdata;
    if (n >= 50) fails++;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  // register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  // register read and compare
  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    `CHK(r, x, "register read")
  endtask

  // wait for the next output sample and compare all four channels
  task automatic expect4(input logic [15:0] a, b, c, d);
    logic [63:0] w;
    int n;
    n = 0;
    while (outq.size() == 0 && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (outq.size() > 0) w = outq.pop_front();
    `CHK(w, {a, b, c, d}, "output sample")
  endtask

  // expected swap mixer result as quarter turns per position
  function automatic logic [31:0] rot(input logic [3:0] m, input int p,
                                      input logic [15:0] i, qq);
    int t;
    t = (m == mix_pkg::CM_P4) ? p : (m == mix_pkg::CM_H2) ? 2 * p :
        (m == mix_pkg::CM_M4) ? 4 - p : 0;
    case (t % 4)
      0: return {i, qq};
      1: return {16'h0 - qq, i};
      2: return {16'h0 - i, 16'h0 - qq};
      default: return {qq, 16'h0 - i};
    endcase
  endfunction

  // verdict and end of run
  task automatic give_verdict();
    if (fails == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    #200000;
    fails++;
    give_verdict();
  end

  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    rst = 1'b1;
    {address, read, write, writedata} = '0;
    byteenable = 4'hF;
    modes = '{mix_pkg::CM_NONE, mix_pkg::CM_H2, mix_pkg::CM_P4,
              mix_pkg::CM_M4};
    eights = '{mix_pkg::CM_P8, mix_pkg::CM_M38, mix_pkg::CM_P38,
               mix_pkg::CM_M8};
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    // reset values and an unmapped word
    rdchk(8'h00, 32'h0);
    for (int k = 0; k < 4; k++) rdchk(8'h10 + 8'(4 * k), 32'h400);
    rdchk(8'hFC, 32'h0);
    // byte lanes merge a partial write into the old word
    byteenable <= 4'h1;
    wr(8'h10, 32'h0000_07FF);
    byteenable <= 4'hF;
    rdchk(8'h10, 32'h4FF);
    wr(8'h10, 32'h400);
    // timing trims reach their channel outputs
    for (int k = 0; k < 4; k++) wr(8'h40 + 8'(4 * k), 32'hA0 + k);
    repeat (4) @(posedge clock);
    `CHK({ch1_trim, ch2_trim, ch3_trim, ch4_trim}, 32'hA0A1A2A3, "trim")
    // swap mixers over one four-sample cycle, gaps in half-rate mode
    foreach (modes[m]) begin
      wr(8'h00, {28'h0, modes[m]});
      for (int p = 0; p < 4; p++) begin
        src.send(p == 0, 16'h0100, 16'h0200, 16'h0300, 16'h0400);
        if (modes[m] == mix_pkg::CM_H2) src.idle(2);
      end
      src.idle(6);
      for (int p = 0; p < 4; p++) begin
        e = rot(modes[m], p, 16'h0100, 16'h0200);
        f = rot(modes[m], p, 16'h0300, 16'h0400);
        expect4(e[31:16], e[15:0], f[31:16], f[15:0]);
      end
    end
    // eighth-rate codes, unscaled with a small input to avoid clipping
    foreach (eights[c]) begin
      wr(8'h00, {27'h0, 1'b1, eights[c]});
      src.send(1'b1, 16'h2000, 16'h0, 16'h0, 16'h0);
      src.idle(6);
      expect4(16'h1FFF, 16'h0, 16'h0, 16'h0);
    end
    // multiplier halving with the option cleared
    wr(8'h00, 32'h8);
    src.send(1'b1, 16'h2000, 16'h0, 16'h0, 16'h0);
    src.idle(6);
    expect4(16'h0FFF, 16'h0, 16'h0, 16'h0);
    // about 3 dB of correction gain makes up half of the 6 dB halving
    wr(8'h10, 32'h5A8);
    src.send(1'b1, 16'h2000, 16'h0, 16'h0, 16'h0);
    src.idle(6);
    expect4(16'h169E, 16'h0, 16'h0, 16'h0);
    // unsupported select code is flagged
    wr(8'h00, 32'h3);
    bus(1'b0, 8'h04, 32'h0, q);
    `CHK(q[3], 1'b1, "bad code flag")
    wr(8'h00, 32'hE);
    bus(1'b0, 8'h04, 32'h0, q);
    `CHK(q[3], 1'b0, "good code flag")
    // gain, offset and saturation
    wr(8'h00, 32'h0);
    wr(8'h10, 32'h200);
    wr(8'h14, 32'h7FF);
    wr(8'h38, 32'h1000);
    wr(8'h3C, 32'hFFF);
    src.send(1'b1, 16'h0100, 16'h0400, 16'h0300, 16'h7F00);
    src.idle(6);
    expect4(16'h0080, 16'h07FF, 16'hF300, 16'h7FFF);
    // skew term per pair, positive and negative
    wr(8'h10, 32'h400);
    wr(8'h20, 32'h100);
    wr(8'h24, 32'hF00);
    src.send(1'b1, 16'h0100, 16'h0400, 16'h0300, 16'h7F00);
    src.idle(6);
    expect4(16'h0140, 16'h07FF, 16'hEB10, 16'h7FFF);
    // mid-run reset brings back the defaults
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    `CHK({ch1_trim, ch2_trim, ch3_trim, ch4_trim}, 32'h0, "trim reset")
    rst <= 1'b0;
    rdchk(8'h20, 32'h0);
    rdchk(8'h14, 32'h400);
    give_verdict();
  end
endmodule
